// File: verilog/uart_fifo_pkg.sv
package uart_fifo_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [2:0] ADDR_DATA = 3'h0;
  localparam logic [2:0] ADDR_IE   = 3'h1;
  localparam logic [2:0] ADDR_IID  = 3'h2;
  localparam logic [2:0] ADDR_LS   = 3'h5;

  // fifo_control fields
  localparam int FC_EN    = 0;
  localparam int FC_RXRST = 1;
  localparam int FC_TXRST = 2;
  localparam int FC_DMA   = 3;
  localparam int FC_TRIG  = 6;

  // interrupt_enable fields
  localparam int IE_RX = 0;
  localparam int IE_TX = 1;
  localparam int IE_LS = 2;
  localparam int IE_MS = 3;

  // interrupt_identification codes, bits 3..0
  localparam logic [3:0] IID_NONE = 4'h1;
  localparam logic [3:0] IID_LS   = 4'h6;
  localparam logic [3:0] IID_RX   = 4'h4;
  localparam logic [3:0] IID_TO   = 4'hc;
  localparam logic [3:0] IID_THR  = 4'h2;
  localparam logic [3:0] IID_MS   = 4'h0;

  // Receive trigger levels in bytes
  localparam logic [4:0] TRIG_1  = 5'h01;
  localparam logic [4:0] TRIG_4  = 5'h04;
  localparam logic [4:0] TRIG_8  = 5'h08;
  localparam logic [4:0] TRIG_14 = 5'h0e;

  // Fifo depth; legacy mode keeps one byte
  localparam logic [4:0] DEPTH     = 5'h10;
  localparam logic [4:0] DEPTH_OFF = 5'h01;

  // Receiver clock ticks per bit is 16 (shift by 4); four chars (by 2)
  localparam int TICK_SHIFT = 4;
  localparam int TO_SHIFT   = 2;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic       brk;
    logic       frm;
    logic       par;
    logic [7:0] data;
  } rx_entry_t;

  typedef enum logic [2:0] {
    THR_IDLE = 3'b001,
    THR_WAIT = 3'b010,
    THR_PEND = 3'b100
  } thr_state_t;

endpackage

// File: verilog/uart_fifo_ctrl.sv
`timescale 1ns/1ps

// How it works
// - Fifo enable bit arms both fifos; other bits need it; toggling flushes.
// - Receive reset bit empties receive fifo and count; self clearing.
// - Transmit reset bit empties transmit fifo and count; self clearing.
// - Dma select bit moves both dma requests from mode 0 to mode 1.
// - Top two control bits choose trigger of 1, 4, 8 or 14 bytes.
// - In fifo mode, data interrupt and code follow fill at or above the trigger; legacy mode raises them on any byte.
// - Line status interrupt outranks received data interrupt.
// - Data ready is set by arrival, cleared when receive fifo empties.
// - Timeout after four idle character times with data waiting.
// - Character times are counted on receiver clock rising edges.
// - Reading one character clears a fired timeout and its timer.
// - Without a timeout, arrival or host read restarts the timer.
// - Empty transmit fifo raises code 2; write or id read clears it.
// - In fifo mode, without two bytes since empty, transmit interrupt waits a char less its stop bit.
// - First transmit interrupt after enable change comes at once.
// - Cleared enables put each direction into polled operation.
// - Polled mode reports no trigger or timeout; fifos still fill.
// - Line status shows holding empty, idle and fifo error bits.
// - Enable register gates four sources; upper nibble reads zero.
// - Legacy mode reads zero in timeout, fifo and error bits.
// - Byte bit 0 is the first bit on the serial line.
// - Priority: line status, receive or timeout, transmit, modem.
// - Timeout code sets bit 3 beside bit 2.
module uart_fifo_ctrl (
  input  wire logic                     clk_i,
  input  wire logic                     rst_i,
  input  wire logic [2:0]               addr_i,
  input  wire logic [7:0]               wdata_i,
  input  wire logic                     wr_i,
  input  wire logic                     rd_i,
  output logic      [7:0]               rdata_o,
  input  wire logic                     rclk_i,
  input  wire logic [3:0]               char_bits_i,
  input  wire logic                     rx_valid_i,
  input  wire uart_fifo_pkg::rx_entry_t rx_char_i,
  input  wire logic                     tx_idle_i,
  output logic                          tx_load_o,
  output logic      [7:0]               tx_data_o,
  input  wire logic                     modem_irq_i,
  output logic                          irq_o,
  output logic                          rx_dma_o,
  output logic                          tx_dma_o
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [3:0]                           interrupt_enable;
    logic                                 fifo_en;
    logic                                 dma_mode;
    logic [1:0]                           trig;
    uart_fifo_pkg::rx_entry_t [15:0]      rx_mem;
    logic [3:0]                           rx_wp;
    logic [3:0]                           rx_rp;
    logic [4:0]                           rx_cnt;
    logic [15:0][7:0]                     tx_mem;
    logic [3:0]                           tx_wp;
    logic [3:0]                           tx_rp;
    logic [4:0]                           tx_cnt;
    logic                                 seen2;
    uart_fifo_pkg::thr_state_t            thr_st;
    logic [9:0]                           dly;
    logic [3:0]                           ls_err;
    logic [2:0]                           rclk_s;
    logic [9:0]                           to_cnt;
    logic                                 to_flag;
    logic [7:0]                           rdata;
    logic                                 irq;
    logic                                 rx_dma;
    logic                                 tx_dma;
    logic [7:0]                           tx_data;
    logic                                 tx_load;
  } state_t;

  state_t s;
  state_t n;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // trigger decode
  function automatic logic [4:0] trig_lvl(input logic [1:0] c);
    unique case (c)
      2'b00: trig_lvl = uart_fifo_pkg::TRIG_1;
      2'b01: trig_lvl = uart_fifo_pkg::TRIG_4;
      2'b10: trig_lvl = uart_fifo_pkg::TRIG_8;
      2'b11: trig_lvl = uart_fifo_pkg::TRIG_14;
    endcase
  endfunction

  // any stored byte with an error
  function automatic logic err_any(input state_t q);
    logic [3:0] k;
    err_any = 1'b0;
    for (int i = 0; i < 16; i++) begin
      k = q.rx_rp + 4'(i);
      if (5'(i) < q.rx_cnt && (q.rx_mem[k].brk | q.rx_mem[k].frm |
                               q.rx_mem[k].par))
        err_any = 1'b1;
    end
  endfunction

  function automatic logic [3:0] iid_f(input state_t q,
                                       input logic   ms);
    if (q.interrupt_enable[uart_fifo_pkg::IE_LS] && q.ls_err != 4'h0)
      iid_f = uart_fifo_pkg::IID_LS;
    else if (q.interrupt_enable[uart_fifo_pkg::IE_RX] && q.rx_cnt != 5'h00 &&
             (!q.fifo_en || q.rx_cnt >= trig_lvl(q.trig)))
      iid_f = uart_fifo_pkg::IID_RX;
    else if (q.interrupt_enable[uart_fifo_pkg::IE_RX] && q.to_flag)
      iid_f = uart_fifo_pkg::IID_TO;
    else if (q.interrupt_enable[uart_fifo_pkg::IE_TX] && q.thr_st == uart_fifo_pkg::THR_PEND)
      iid_f = uart_fifo_pkg::IID_THR;
    else if (q.interrupt_enable[uart_fifo_pkg::IE_MS] && ms)
      iid_f = uart_fifo_pkg::IID_MS;
    else
      iid_f = uart_fifo_pkg::IID_NONE;
  endfunction

  logic       wr_data;
  logic       rd_data;
  logic       wr_fc;
  logic       rd_iid;
  logic       rd_ls;
  logic       rise;
  logic       en_chg;
  logic       rx_clr;
  logic       tx_clr;
  logic       pop;
  logic       push;
  logic       empt;
  logic [4:0] cap;
  logic [3:0] iid;
  logic [7:0] ls;

  assign wr_data = wr_i && addr_i == uart_fifo_pkg::ADDR_DATA;
  assign rd_data = rd_i && addr_i == uart_fifo_pkg::ADDR_DATA;
  assign wr_fc   = wr_i && addr_i == uart_fifo_pkg::ADDR_IID;
  assign rd_iid  = rd_i && addr_i == uart_fifo_pkg::ADDR_IID;
  assign rd_ls   = rd_i && addr_i == uart_fifo_pkg::ADDR_LS;
  assign iid     = iid_f(s, modem_irq_i);

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    n       = s;
    rise    = s.rclk_s[1] & ~s.rclk_s[2];
    n.rclk_s = {s.rclk_s[1:0], rclk_i};
    cap     = s.fifo_en ? uart_fifo_pkg::DEPTH : uart_fifo_pkg::DEPTH_OFF;
    // line status assembly; error bit only in fifo mode
    ls = {s.fifo_en & err_any(s),
          s.tx_cnt == 5'h00 && tx_idle_i && !s.tx_load,
          s.tx_cnt == 5'h00, s.ls_err[3:0] == 4'h0 ? 4'h0 : s.ls_err,
          s.rx_cnt != 5'h00};

    // Register writes
    // four enable bits held
    if (wr_i && addr_i == uart_fifo_pkg::ADDR_IE)
      n.interrupt_enable = wdata_i[3:0];
    // enable change flushes, other bits need enable
    en_chg = wr_fc && wdata_i[uart_fifo_pkg::FC_EN] != s.fifo_en;
    rx_clr = en_chg;
    tx_clr = en_chg;
    if (wr_fc) begin
      n.fifo_en = wdata_i[uart_fifo_pkg::FC_EN];
      if (wdata_i[uart_fifo_pkg::FC_EN]) begin
        n.dma_mode = wdata_i[uart_fifo_pkg::FC_DMA];
        n.trig     = wdata_i[uart_fifo_pkg::FC_TRIG +: 2];
        rx_clr = rx_clr | wdata_i[uart_fifo_pkg::FC_RXRST];
        tx_clr = tx_clr | wdata_i[uart_fifo_pkg::FC_TXRST];
      end
    end

    // Read data, present only the cycle after the strobe
    n.rdata = 8'h00;
    if (rd_i) begin
      unique case (addr_i)
        uart_fifo_pkg::ADDR_DATA: n.rdata = s.rx_mem[s.rx_rp].data;
        uart_fifo_pkg::ADDR_IE:   n.rdata = {4'h0, s.interrupt_enable};
        // fifo bits zero in legacy mode
        uart_fifo_pkg::ADDR_IID:  n.rdata = {s.fifo_en, s.fifo_en, 2'b00,
                                             iid};
        uart_fifo_pkg::ADDR_LS:   n.rdata = ls;
        default:                  n.rdata = 8'h00;
      endcase
    end

    // Line errors: read clears, new error wins
    if (rd_ls)
      n.ls_err = 4'h0;

    // Receive fifo
    pop  = rd_data && s.rx_cnt != 5'h00;
    push = rx_valid_i && (s.rx_cnt < cap || pop);
    if (rx_valid_i) begin
      n.ls_err[3:1] = n.ls_err[3:1] |
                      {rx_char_i.brk, rx_char_i.frm, rx_char_i.par};
      if (!push)
        n.ls_err[0] = 1'b1;
    end
    if (rx_clr) begin
      n.rx_wp  = 4'h0;
      n.rx_rp  = 4'h0;
      n.rx_cnt = 5'h00;
    end else begin
      if (pop)
        n.rx_rp = s.rx_rp + 4'h1;
      // entry keeps error status; arrival sets data ready
      if (push) begin
        n.rx_mem[s.rx_wp] = rx_char_i;
        n.rx_wp           = s.rx_wp + 4'h1;
      end
      n.rx_cnt = s.rx_cnt + 5'(push) - 5'(pop);
    end

    if (rx_clr || !s.fifo_en || !s.interrupt_enable[uart_fifo_pkg::IE_RX] ||
        n.rx_cnt == 5'h00) begin
      n.to_cnt  = 10'h000;
      n.to_flag = 1'b0;
    // read clears a fired timeout and timer
    end else if (pop) begin
      n.to_cnt  = 10'h000;
      n.to_flag = 1'b0;
    end else if (push && !s.to_flag) begin
      n.to_cnt = 10'h000;
    end else if (rise && !s.to_flag) begin
      n.to_cnt = s.to_cnt + 10'h001;
      if (s.to_cnt + 10'h001 >=
          10'({char_bits_i, 6'h00} >> (6 - uart_fifo_pkg::TICK_SHIFT -
                                      uart_fifo_pkg::TO_SHIFT)))
        n.to_flag = 1'b1;
    end

    // Transmit fifo
    n.tx_load = 1'b0;
    empt      = 1'b0;
    if (tx_clr) begin
      n.tx_wp  = 4'h0;
      n.tx_rp  = 4'h0;
      n.tx_cnt = 5'h00;
      empt     = s.tx_cnt != 5'h00;
    end else begin
      if (wr_data && s.tx_cnt < cap) begin
        n.tx_mem[s.tx_wp] = wdata_i;
        n.tx_wp           = s.tx_wp + 4'h1;
      end
      // byte handed whole; shifter sends bit 0 first
      if (tx_idle_i && !s.tx_load && s.tx_cnt != 5'h00) begin
        n.tx_data = s.tx_mem[s.tx_rp];
        n.tx_load = 1'b1;
        n.tx_rp   = s.tx_rp + 4'h1;
      end
      n.tx_cnt = s.tx_cnt + 5'(wr_data && s.tx_cnt < cap) - 5'(n.tx_load);
      empt     = s.tx_cnt != 5'h00 && n.tx_cnt == 5'h00;
    end
    if (n.tx_cnt >= 5'h02)
      n.seen2 = 1'b1;

    // Transmit empty interrupt
    // write or id read clears
    unique case (s.thr_st)
      uart_fifo_pkg::THR_IDLE: ;
      uart_fifo_pkg::THR_WAIT: begin
        if (wr_data)
          n.thr_st = uart_fifo_pkg::THR_IDLE;
        else if (rise) begin
          n.dly = s.dly + 10'h001;
          // one character less final stop bit
          if (s.dly + 10'h001 >=
              10'({char_bits_i - 4'h1, 4'h0} >>
                  (4 - uart_fifo_pkg::TICK_SHIFT)))
            n.thr_st = uart_fifo_pkg::THR_PEND;
        end
      end
      uart_fifo_pkg::THR_PEND: begin
        if (wr_data || (rd_iid && iid == uart_fifo_pkg::IID_THR))
          n.thr_st = uart_fifo_pkg::THR_IDLE;
      end
      default: n.thr_st = uart_fifo_pkg::THR_IDLE;
    endcase
    if (en_chg) begin
      n.thr_st = uart_fifo_pkg::THR_PEND;
      n.seen2  = 1'b0;
    end else if (empt) begin
      n.dly    = 10'h000;
      n.seen2  = 1'b0;
      n.thr_st = (s.seen2 || !s.fifo_en) ? uart_fifo_pkg::THR_PEND
                                         : uart_fifo_pkg::THR_WAIT;
    end

    if (s.fifo_en && s.dma_mode) begin
      n.rx_dma = s.rx_cnt >= trig_lvl(s.trig) || s.to_flag;
      n.tx_dma = s.tx_cnt < uart_fifo_pkg::DEPTH;
    end else begin
      n.rx_dma = s.rx_cnt != 5'h00;
      n.tx_dma = s.tx_cnt == 5'h00;
    end
    n.irq = iid != uart_fifo_pkg::IID_NONE;
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s        <= '0;
      s.thr_st <= uart_fifo_pkg::THR_IDLE;
    end else begin
      s <= n;
    end
  end

  assign rdata_o   = s.rdata;
  assign tx_load_o = s.tx_load;
  assign tx_data_o = s.tx_data;
  assign irq_o     = s.irq;
  assign rx_dma_o  = s.rx_dma;
  assign tx_dma_o  = s.tx_dma;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence s_rd_ls;
    rd_i && addr_i == uart_fifo_pkg::ADDR_LS;
  endsequence
  sequence s_rd_iid;
    rd_i && addr_i == uart_fifo_pkg::ADDR_IID;
  endsequence

  property p_enchg;
    wr_fc && wdata_i[0] != s.fifo_en |=> s.rx_cnt == 5'h00 &&
      s.tx_cnt == 5'h00 && s.thr_st == uart_fifo_pkg::THR_PEND;
  endproperty
  a_enchg: assert property (p_enchg) else $error("enable change");

  property p_rxrst;
    wr_fc && s.fifo_en && wdata_i[0] && wdata_i[1] |=> s.rx_cnt == 5'h00;
  endproperty
  a_rxrst: assert property (p_rxrst) else $error("rx flush");

  property p_txrst;
    wr_fc && s.fifo_en && wdata_i[0] && wdata_i[2] |=> s.tx_cnt == 5'h00;
  endproperty
  a_txrst: assert property (p_txrst) else $error("tx flush");

  property p_prio;
    s_rd_iid ##0 s.interrupt_enable[2] && s.ls_err != 4'h0 |=> rdata_o[3:0] == 4'h6;
  endproperty
  a_prio: assert property (p_prio) else $error("line prio");

  property p_dr;
    s_rd_ls |=> rdata_o[0] == ($past(s.rx_cnt) != 5'h00);
  endproperty
  a_dr: assert property (p_dr) else $error("data ready");

  property p_toclr;
    s.to_flag && rd_data |=> !s.to_flag;
  endproperty
  a_toclr: assert property (p_toclr) else $error("timeout clear");

  property p_thrclr;
    s.thr_st == uart_fifo_pkg::THR_PEND && wr_data && !en_chg
      |=> s.thr_st != uart_fifo_pkg::THR_PEND;
  endproperty
  a_thrclr: assert property (p_thrclr) else $error("thr clear");

  property p_polled;
    !s.interrupt_enable[0] |=> !s.to_flag;
  endproperty
  a_polled: assert property (p_polled) else $error("polled");

  property p_ie;
    rd_i && addr_i == uart_fifo_pkg::ADDR_IE |=> rdata_o[7:4] == 4'h0;
  endproperty
  a_ie: assert property (p_ie) else $error("ie upper");

  property p_legacy;
    s_rd_iid ##0 !s.fifo_en |=> rdata_o[7:6] == 2'b00 && !rdata_o[3];
  endproperty
  a_legacy: assert property (p_legacy) else $error("legacy bits");

endmodule // uart_fifo_ctrl

// File: verification/uart_line_model.sv
`timescale 1ns/1ps

module uart_line_model #(
  parameter int BUSY = 20
) (
  input  wire logic                clk_i,
  input  wire logic                rst_i,
  input  wire logic                stall_i,
  input  wire logic                tx_load_i,
  input  wire logic [7:0]          tx_data_i,
  output logic                     tx_idle_o,
  output logic                     rx_valid_o,
  output uart_fifo_pkg::rx_entry_t rx_char_o
);
  int         busy;
  logic [7:0] sent [$];

  // ----------------------------------------
  // Transmit shifter
  // ----------------------------------------
  // Busy for BUSY clock cycles after every load
  always @(posedge clk_i) begin
    if (rst_i) begin
      busy <= 0;
    end else if (tx_load_i) begin
      busy <= BUSY;
      sent.push_back(tx_data_i);
    end else if (busy != 0) begin
      busy <= busy - 1;
    end
  end

  assign tx_idle_o = (busy == 0) && !stall_i;

  // ----------------------------------------
  // Receive shifter
  // ----------------------------------------
  initial begin
    rx_valid_o = 1'b0;
    rx_char_o  = '0;
  end

  // One character per call; the bus shows garbage once released
  task automatic put(input uart_fifo_pkg::rx_entry_t c);
    @(posedge clk_i);
    rx_valid_o <= 1'b1;
    rx_char_o  <= c;
    @(posedge clk_i);
    rx_valid_o <= 1'b0;
    rx_char_o  <= ~c;
  endtask
endmodule // uart_line_model

// File: verification/tb_top.sv
`timescale 1ns/1ps

`define CHK(got, exp) \
  begin \
    comparisons++; \
    if ((got) !== (exp)) begin \
      failures++; \
      $display("MISMATCH %0t got %h expected %h", $time, got, exp); \
    end \
  end

module tb_top;
  typedef struct {
    logic [2:0] a;
    logic [7:0] w;
    int         n;
    logic [2:0] ra;
    logic [7:0] exp;
  } row_t;

  logic                     clk_i = 1'b0;
  logic                     rst_i = 1'b1;
  logic [2:0]               addr  = '0;
  logic [7:0]               wdata = '0;
  logic                     wr    = 1'b0;
  logic                     rd    = 1'b0;
  logic                     rclk  = 1'b0;
  logic                     stall = 1'b0;
  logic                     modem = 1'b0;
  logic [3:0]               char_bits = 4'ha;
  logic [7:0]               rdata;
  logic                     rx_valid;
  uart_fifo_pkg::rx_entry_t rx_char;
  logic                     tx_idle;
  logic                     tx_load;
  logic [7:0]               tx_data;
  logic                     irq;
  logic                     rx_dma;
  logic                     tx_dma;
  int                       failures    = 0;
  int                       comparisons = 0;
  logic [7:0]               txq [4] = '{8'h3c, 8'ha1, 8'hb2, 8'hc3};
  row_t                     rows [13] = '{
    '{3'h1, 8'hff, 0, 3'h1, 8'h0f},
    '{3'h1, 8'h01, 0, 3'h1, 8'h01},
    '{3'h3, 8'hff, 0, 3'h3, 8'h00},
    '{3'h7, 8'hff, 0, 3'h6, 8'h00},
    '{3'h2, 8'h07, 0, 3'h2, 8'hc1},
    '{3'h2, 8'h07, 1, 3'h2, 8'hc4},
    '{3'h2, 8'h47, 3, 3'h2, 8'hc1},
    '{3'h2, 8'h47, 4, 3'h2, 8'hc4},
    '{3'h2, 8'h87, 7, 3'h2, 8'hc1},
    '{3'h2, 8'h87, 8, 3'h2, 8'hc4},
    '{3'h2, 8'hc7, 13, 3'h2, 8'hc1},
    '{3'h2, 8'hc7, 17, 3'h5, 8'h63},
    '{3'h4, 8'hff, 0, 3'h5, 8'h61}
  };

  always #4 clk_i = ~clk_i;

  // Receiver clock, 4 system clocks per period, unrelated phase
  initial #3 forever #16 rclk = ~rclk;

  uart_fifo_ctrl i_uart_fifo_ctrl (
    .clk_i       (clk_i),
    .rst_i       (rst_i),
    .addr_i      (addr),
    .wdata_i     (wdata),
    .wr_i        (wr),
    .rd_i        (rd),
    .rdata_o     (rdata),
    .rclk_i      (rclk),
    .char_bits_i (char_bits),
    .rx_valid_i  (rx_valid),
    .rx_char_i   (rx_char),
    .tx_idle_i   (tx_idle),
    .tx_load_o   (tx_load),
    .tx_data_o   (tx_data),
    .modem_irq_i (modem),
    .irq_o       (irq),
    .rx_dma_o    (rx_dma),
    .tx_dma_o    (tx_dma)
  );

  uart_line_model i_uart_line_model (
    .clk_i      (clk_i),
    .rst_i      (rst_i),
    .stall_i    (stall),
    .tx_load_i  (tx_load),
    .tx_data_i  (tx_data),
    .tx_idle_o  (tx_idle),
    .rx_valid_o (rx_valid),
    .rx_char_o  (rx_char)
  );

  // ----------------------------------------
  // Bus and stimulus tasks
  // ----------------------------------------
  task automatic wr_reg(input logic [2:0] a, input logic [7:0] w);
    @(posedge clk_i);
    addr  <= a;
    wdata <= w;
    wr    <= 1'b1;
    @(posedge clk_i);
    wr    <= 1'b0;
  endtask

  task automatic rd_reg(input logic [2:0] a, input logic [7:0] e);
    @(posedge clk_i);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk_i);
    rd   <= 1'b0;
    #1;
    `CHK(rdata, e)
  endtask

  task automatic push(input int n);
    for (int k = 0; k < n; k++) begin
      i_uart_line_model.put({3'b000, 8'(k + 1)});
    end
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask

  task automatic tally_and_finish();
    if (failures == 0 && comparisons > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  initial begin
    repeat (30000) @(posedge clk_i);
    failures++;
    tally_and_finish();
  end

  // ----------------------------------------
  // Test sequence
  // ----------------------------------------
  initial begin
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    foreach (rows[i]) begin
      wr_reg(rows[i].a, rows[i].w);
      push(rows[i].n);
      idle(3);
      rd_reg(rows[i].ra, rows[i].exp);
    end
    // Second reset in mid-run
    @(posedge clk_i);
    rst_i <= 1'b1;
    idle(2);
    @(posedge clk_i);
    rst_i <= 1'b0;
    idle(2);
    `CHK(irq, 1'b0)
    `CHK(tx_dma, 1'b1)
    rd_reg(3'h5, 8'h60);
    rd_reg(3'h2, 8'h01);
    rd_reg(3'h1, 8'h00);
    // Legacy mode with break, framing and parity errors
    i_uart_line_model.put(11'h7a5);
    idle(3);
    rd_reg(3'h5, 8'h7d);
    rd_reg(3'h0, 8'ha5);
    // Line status beats received data
    wr_reg(3'h2, 8'h01);
    wr_reg(3'h1, 8'h05);
    i_uart_line_model.put(11'h15a);
    idle(3);
    `CHK(irq, 1'b1)
    rd_reg(3'h2, 8'hc6);
    rd_reg(3'h5, 8'he5);
    rd_reg(3'h2, 8'hc4);
    rd_reg(3'h0, 8'h5a);
    rd_reg(3'h5, 8'h60);
    // Character timeout
    wr_reg(3'h2, 8'hc1);
    wr_reg(3'h1, 8'h01);
    push(2);
    idle(2400);
    `CHK(irq, 1'b0)
    idle(400);
    `CHK(irq, 1'b1)
    rd_reg(3'h2, 8'hcc);
    rd_reg(3'h0, 8'h01);
    rd_reg(3'h2, 8'hc1);
    idle(2300);
    `CHK(irq, 1'b0)
    idle(500);
    `CHK(irq, 1'b1)
    // Polled receive
    wr_reg(3'h1, 8'h00);
    push(13);
    idle(2800);
    `CHK(irq, 1'b0)
    rd_reg(3'h2, 8'hc1);
    rd_reg(3'h5, 8'h61);
    wr_reg(3'h2, 8'hc3);
    rd_reg(3'h5, 8'h60);
    // Dma signalling modes, full transmit fifo
    wr_reg(3'h2, 8'h41);
    push(1);
    idle(3);
    `CHK(rx_dma, 1'b1)
    wr_reg(3'h2, 8'h49);
    idle(3);
    `CHK(rx_dma, 1'b0)
    push(3);
    idle(3);
    `CHK(rx_dma, 1'b1)
    @(posedge clk_i);
    stall <= 1'b1;
    for (int k = 0; k < 17; k++) wr_reg(3'h0, 8'(k));
    idle(3);
    `CHK(tx_dma, 1'b0)
    wr_reg(3'h2, 8'h45);
    idle(3);
    `CHK(tx_dma, 1'b1)
    rd_reg(3'h5, 8'h21);
    // Transmit empty interrupt
    @(posedge clk_i);
    stall <= 1'b0;
    wr_reg(3'h2, 8'h00);
    wr_reg(3'h1, 8'h02);
    idle(3);
    rd_reg(3'h2, 8'h02);
    rd_reg(3'h2, 8'h01);
    wr_reg(3'h2, 8'h01);
    idle(3);
    `CHK(irq, 1'b1)
    rd_reg(3'h2, 8'hc2);
    rd_reg(3'h2, 8'hc1);
    wr_reg(3'h0, 8'h3c);
    idle(300);
    `CHK(irq, 1'b0)
    idle(400);
    `CHK(irq, 1'b1)
    @(posedge clk_i);
    modem <= 1'b1;
    wr_reg(3'h1, 8'h0a);
    rd_reg(3'h2, 8'hc2);
    rd_reg(3'h2, 8'hc0);
    @(posedge clk_i);
    modem <= 1'b0;
    wr_reg(3'h0, 8'ha1);
    wr_reg(3'h0, 8'hb2);
    wr_reg(3'h0, 8'hc3);
    idle(100);
    `CHK(irq, 1'b1)
    foreach (txq[i]) `CHK(i_uart_line_model.sent[i], txq[i])
    // Shorter character shortens the transmit delay
    @(posedge clk_i);
    char_bits <= 4'h5;
    wr_reg(3'h0, 8'h5b);
    idle(200);
    `CHK(irq, 1'b0)
    idle(150);
    `CHK(irq, 1'b1)
    `CHK(i_uart_line_model.sent[4], 8'h5b)
    tally_and_finish();
  end
endmodule // tb_top
